// ===== core/alf_alu.sv
`default_nettype none
module alf_alu (
  // Operation and operands.
  input wire alf_pkg::alf_op_e op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic [7:0] flags_in,
  // Result.
  output logic [7:0] result,
  output logic [7:0] flags_out
);
  // ----------------------------------------
  // Shared adder for every arithmetic form.
  // ----------------------------------------
  // One adder serves add, subtract, step and negate so the flags agree.
  wire is_sub = (op == alf_pkg::OP_SUB) || (op == alf_pkg::OP_SBC) ||
      (op == alf_pkg::OP_CP) || (op == alf_pkg::OP_DEC) || (op == alf_pkg::OP_NEG);
  wire use_c = (op == alf_pkg::OP_ADC) || (op == alf_pkg::OP_SBC);
  wire cin = use_c & flags_in[alf_pkg::FB_C];
  wire step = (op == alf_pkg::OP_INC) || (op == alf_pkg::OP_DEC);
  wire [7:0] x = (op == alf_pkg::OP_NEG) ? 8'h00 : a;
  wire [7:0] y = step ? 8'h01 : ((op == alf_pkg::OP_NEG) ? a : b);
  wire [8:0] sum = is_sub ? ({1'b0, x} - {1'b0, y} - {8'h00, cin}) :
      ({1'b0, x} + {1'b0, y} + {8'h00, cin});
  wire [4:0] nib = is_sub ? ({1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin}) :
      ({1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin});
  wire [7:0] r = sum[7:0];
  wire rz = (r == 8'h00);
  wire ov_add = (x[7] == y[7]) && (r[7] != x[7]);
  wire ov_sub = (x[7] != y[7]) && (r[7] != x[7]);
  wire [7:0] l_and = a & b;
  wire [7:0] l_or = a | b;
  wire [7:0] l_xor = a ^ b;
  wire old_c = flags_in[alf_pkg::FB_C];
  // ----------------------------------------
  // Result and flag selection.
  // ----------------------------------------
  // Bit 8 of the sum is carry for adds and borrow for subtracts.
  always_comb begin
    result = r;
    flags_out = flags_in;
    case (op)
      alf_pkg::OP_ADD, alf_pkg::OP_ADC: begin
        flags_out = alf_pkg::alf_flags(r[7], rz, nib[4], ov_add, 1'b0, sum[8]);
      end
      alf_pkg::OP_SUB, alf_pkg::OP_SBC, alf_pkg::OP_CP: begin
        flags_out = alf_pkg::alf_flags(r[7], rz, nib[4], ov_sub, 1'b1, sum[8]);
      end
      alf_pkg::OP_AND: begin
        result = l_and;
        flags_out = alf_pkg::alf_flags(l_and[7], l_and == 8'h00, 1'b1, ~^l_and,
            1'b0, 1'b0);
      end
      alf_pkg::OP_OR: begin
        result = l_or;
        flags_out = alf_pkg::alf_flags(l_or[7], l_or == 8'h00, 1'b0, ~^l_or,
            1'b0, 1'b0);
      end
      alf_pkg::OP_XOR: begin
        result = l_xor;
        flags_out = alf_pkg::alf_flags(l_xor[7], l_xor == 8'h00, 1'b0, ~^l_xor,
            1'b0, 1'b0);
      end
      alf_pkg::OP_INC: begin
        flags_out = alf_pkg::alf_flags(r[7], rz, nib[4], a == alf_pkg::INC_OV_VAL,
            1'b0, old_c);
      end
      alf_pkg::OP_DEC: begin
        flags_out = alf_pkg::alf_flags(r[7], rz, nib[4], a == alf_pkg::DEC_OV_VAL,
            1'b1, old_c);
      end
      alf_pkg::OP_NEG: begin
        flags_out = alf_pkg::alf_flags(r[7], rz, nib[4], a == alf_pkg::NEG_OV_VAL,
            1'b1, a != 8'h00);
      end
      alf_pkg::OP_CPL: begin
        result = ~a;
        flags_out[alf_pkg::FB_H] = 1'b1;
        flags_out[alf_pkg::FB_N] = 1'b1;
      end
      alf_pkg::OP_CCF: begin
        result = a;
        flags_out[alf_pkg::FB_C] = ~old_c;
        flags_out[alf_pkg::FB_H] = old_c;
        flags_out[alf_pkg::FB_N] = 1'b0;
      end
      alf_pkg::OP_SCF: begin
        result = a;
        flags_out[alf_pkg::FB_C] = 1'b1;
        flags_out[alf_pkg::FB_H] = 1'b0;
        flags_out[alf_pkg::FB_N] = 1'b0;
      end
      default: begin
        result = a;
      end
    endcase
  end
endmodule
`default_nettype wire

// ===== core/alf_core.sv
// Functional notes
// - Add-with-carry register: A+r+carry; half and carry from bits 3, 7; one M cycle.
// - Subtract register, opcode 10010r: N set, borrow flags, overflow.
// - Subtract-with-borrow register, opcode 10011r: A-r-carry, flags as subtract.
// - AND: stores A and operand; H set, parity even, N and C cleared.
// - OR: stores A or operand; H, N, C cleared; parity even; S, Z.
// - XOR: stores A xor operand; H, N, C cleared; parity even; S, Z.
// - Compare sets subtract flags and leaves the accumulator untouched.
// - Increment register: H from bit 3, N cleared, C kept, overflow at 7F.
// - Decrement register: N set, C kept, H borrow, overflow at 80.
// - Complement accumulator: invert bits, set H and N, keep others.
// - Decimal adjust corrects accumulator; S, Z, parity from result, N kept.
// - Correction from carry, nibbles, half; adds 00/06/60/66 or 00/FA/A0/9A.
// - Negate: zero minus A; overflow at 80; carry unless 00; N set.
// - Complement carry: invert C, old C into H, clear N, keep rest.
// - Immediate forms take the following byte; two M cycles, 4 then 3.
// - Pointer-pair memory forms read one byte; two M cycles, 4 then 3.
// - Indexed forms pick index by prefix, add signed offset; 4,4,3,5,3.
// - Add-with-carry memory: A plus memory byte plus carry, flags as register.
`default_nettype none
module alf_core (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Operand memory read port.
  output logic mem_rd,
  output logic [15:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  // Execution status.
  output logic busy,
  output logic op_done
);
  // ----------------------------------------
  // Types and storage.
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } alf_state_e;

  alf_state_e state;
  alf_state_e next_state;
  logic [7:0] gpr [0:7];
  logic [7:0] flags;
  logic [15:0] ix;
  logic [15:0] iy;
  logic [2:0] prefix;
  logic [7:0] operand;
  logic [7:0] opcode;
  logic [7:0] mem_byte;
  logic mem_pending;
  alf_pkg::alf_mode_e mode;
  logic [2:0] m_idx;
  logic [2:0] t_idx;
  logic illegal;
  logic [7:0] rd_mux;

  // ----------------------------------------
  // Decode functions.
  // ----------------------------------------
  // Sorts an opcode and prefix into an addressing form, or refuses it.
  function automatic alf_pkg::alf_mode_e decode_mode(input logic [7:0] op,
      input logic [2:0] pfx);
    logic [1:0] grp;
    logic [2:0] lo;
    logic [2:0] hi;
    grp = op[7:6];
    lo = op[2:0];
    hi = op[5:3];
    if (pfx[alf_pkg::PB_EXT]) begin
      decode_mode = (op == alf_pkg::OPC_NEG) ? alf_pkg::MD_EXT : alf_pkg::MD_BAD;
    end else if (grp == alf_pkg::OG_ALU) begin
      if (lo != alf_pkg::RC_MEM) begin
        decode_mode = alf_pkg::MD_REG;
      end else if (pfx[alf_pkg::PB_INDEXED]) begin
        decode_mode = alf_pkg::MD_IDX;
      end else begin
        decode_mode = alf_pkg::MD_HL;
      end
    end else if (grp == alf_pkg::OG_IMM && lo == alf_pkg::LO_IMM) begin
      decode_mode = alf_pkg::MD_IMM;
    end else if (grp == alf_pkg::OG_MISC && (lo == alf_pkg::LO_INC ||
        lo == alf_pkg::LO_DEC) && hi != alf_pkg::RC_MEM) begin
      decode_mode = alf_pkg::MD_REG;
    end else if (op == alf_pkg::OPC_DAA || op == alf_pkg::OPC_CPL ||
        op == alf_pkg::OPC_SCF || op == alf_pkg::OPC_CCF) begin
      decode_mode = alf_pkg::MD_REG;
    end else begin
      decode_mode = alf_pkg::MD_BAD;
    end
  endfunction

  // Length in T states of machine cycle m for a given form.
  function automatic logic [2:0] m_len(input alf_pkg::alf_mode_e md,
      input logic [2:0] m);
    case (md)
      alf_pkg::MD_IMM, alf_pkg::MD_HL: begin
        m_len = (m == 3'h0) ? alf_pkg::TS_FETCH : alf_pkg::TS_READ;
      end
      alf_pkg::MD_IDX: begin
        case (m)
          3'h0, 3'h1: m_len = alf_pkg::TS_FETCH;
          3'h3: m_len = alf_pkg::TS_IDX_ADD;
          default: m_len = alf_pkg::TS_READ;
        endcase
      end
      default: begin
        m_len = alf_pkg::TS_FETCH;
      end
    endcase
  endfunction

  // Number of machine cycles for a given form.
  function automatic logic [2:0] m_count(input alf_pkg::alf_mode_e md);
    case (md)
      alf_pkg::MD_IMM, alf_pkg::MD_HL, alf_pkg::MD_EXT: m_count = alf_pkg::MC_TWO;
      alf_pkg::MD_IDX: m_count = alf_pkg::MC_IDX;
      default: m_count = alf_pkg::MC_ONE;
    endcase
  endfunction

  // ----------------------------------------
  // Opcode fields of the running operation.
  // ----------------------------------------
  wire [1:0] grp = opcode[7:6];
  wire [2:0] fld_hi = opcode[5:3];
  wire [2:0] fld_lo = opcode[2:0];
  wire is_ext = (mode == alf_pkg::MD_EXT);
  wire is_alu = !is_ext && (grp == alf_pkg::OG_ALU || grp == alf_pkg::OG_IMM);
  wire is_inc = !is_ext && grp == alf_pkg::OG_MISC && fld_lo == alf_pkg::LO_INC;
  wire is_dec = !is_ext && grp == alf_pkg::OG_MISC && fld_lo == alf_pkg::LO_DEC;
  wire is_step = is_inc || is_dec;
  wire [2:0] src = is_step ? fld_hi : fld_lo;
  wire uses_mem = (mode == alf_pkg::MD_HL) || (mode == alf_pkg::MD_IDX);

  // The operation code follows the middle field, so the enum order matters.
  wire alf_pkg::alf_op_e alu_op = is_ext ? alf_pkg::OP_NEG :
      is_alu ? alf_pkg::alf_op_e'({1'b0, fld_hi}) :
      is_inc ? alf_pkg::OP_INC :
      is_dec ? alf_pkg::OP_DEC :
      (opcode == alf_pkg::OPC_CPL) ? alf_pkg::OP_CPL :
      (opcode == alf_pkg::OPC_SCF) ? alf_pkg::OP_SCF :
      (opcode == alf_pkg::OPC_CCF) ? alf_pkg::OP_CCF : alf_pkg::OP_DAA;

  // ----------------------------------------
  // Operand selection and datapath.
  // ----------------------------------------
  // Immediate byte, memory byte or register, by addressing form.
  wire [7:0] alu_a = is_step ? gpr[src] : gpr[alf_pkg::RC_ACC];
  wire [7:0] alu_b = (mode == alf_pkg::MD_IMM) ? operand :
      uses_mem ? mem_byte : gpr[src];
  wire [7:0] alu_res;
  wire [7:0] alu_flags;
  wire [7:0] daa_res;
  wire [7:0] daa_flags;

  alf_alu u_alu (
    .op(alu_op),
    .a(alu_a),
    .b(alu_b),
    .flags_in(flags),
    .result(alu_res),
    .flags_out(alu_flags)
  );

  alf_daa u_daa (
    .a(gpr[alf_pkg::RC_ACC]),
    .flags_in(flags),
    .result(daa_res),
    .flags_out(daa_flags)
  );

  wire is_daa = (alu_op == alf_pkg::OP_DAA);
  wire [7:0] new_res = is_daa ? daa_res : alu_res;
  wire [7:0] new_flags = is_daa ? daa_flags : alu_flags;
  // Compare and the carry operations leave the accumulator alone.
  wire to_acc = !is_step && alu_op != alf_pkg::OP_CP &&
      alu_op != alf_pkg::OP_CCF && alu_op != alf_pkg::OP_SCF;
  wire [2:0] wb_idx = is_step ? src : alf_pkg::RC_ACC;

  // ----------------------------------------
  // Sequencing of machine cycles and T states.
  // ----------------------------------------
  wire run = (state == ST_RUN);
  wire last_t = (t_idx == m_len(mode, m_idx) - 3'h1);
  wire last_m = (m_idx == m_count(mode) - 3'h1);
  wire commit = run && last_t && last_m;
  wire wb_en = commit && (is_step || to_acc);
  wire wr_ok = reg_wr && !run;
  wire hit_op = wr_ok && reg_addr == alf_pkg::RA_OPCODE;
  wire alf_pkg::alf_mode_e start_mode = decode_mode(reg_wdata, prefix);
  wire start = hit_op && start_mode != alf_pkg::MD_BAD;
  wire refuse = hit_op && start_mode == alf_pkg::MD_BAD;
  // Index base and signed offset for the indexed forms.
  wire [15:0] idx_base = prefix[alf_pkg::PB_INDEX_SEL] ? iy : ix;
  wire [15:0] disp = {{8{operand[7]}}, operand};
  wire [15:0] hl = {gpr[alf_pkg::RC_H], gpr[alf_pkg::RC_L]};
  wire [15:0] start_addr = (start_mode == alf_pkg::MD_IDX) ?
      idx_base + disp : hl;

  // The read goes out at the first T state of the last machine cycle,
  // which leaves two T states for the byte to land before the commit.
  assign mem_rd = ce && run && uses_mem && last_m && t_idx == 3'h0;
  assign busy = run;

  // Two states are enough: the counters carry the timing.
  always_comb begin
    case (state)
      ST_IDLE: next_state = start ? ST_RUN : ST_IDLE;
      ST_RUN: next_state = commit ? ST_IDLE : ST_RUN;
      default: next_state = ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Machine cycle and T state counters.
  always_ff @(posedge clk) begin
    if (srst || (ce && (start || !run))) begin
      m_idx <= 3'h0;
      t_idx <= 3'h0;
    end else if (ce && last_t) begin
      m_idx <= m_idx + 3'h1;
      t_idx <= 3'h0;
    end else if (ce) begin
      t_idx <= t_idx + 3'h1;
    end
  end

  // Operation capture at start.
  always_ff @(posedge clk) begin
    if (srst) begin
      opcode <= alf_pkg::RST_BYTE;
      mode <= alf_pkg::MD_REG;
      mem_addr <= 16'h0000;
    end else if (ce && start) begin
      opcode <= reg_wdata;
      mode <= start_mode;
      mem_addr <= start_addr;
    end
  end

  // The memory answers in the very next clock, so this capture ignores
  // the enable; a frozen cycle there would otherwise drop the byte.
  always_ff @(posedge clk) begin
    if (srst) begin
      mem_pending <= 1'b0;
      mem_byte <= alf_pkg::RST_BYTE;
    end else begin
      mem_pending <= mem_rd;
      if (mem_pending) begin
        mem_byte <= mem_rdata;
      end
    end
  end

  // Completion pulse and the refused-opcode flag; a refusal beats a clear.
  always_ff @(posedge clk) begin
    if (srst) begin
      op_done <= 1'b0;
      illegal <= 1'b0;
    end else if (ce) begin
      op_done <= commit;
      if (refuse) begin
        illegal <= 1'b1;
      end else if (wr_ok && reg_addr == alf_pkg::RA_STATUS &&
          reg_wdata[alf_pkg::SB_ILLEGAL]) begin
        illegal <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Byte registers and flags.
  // ----------------------------------------
  // Software writes are refused while busy, so they never meet a commit.
  for (genvar i = 0; i < 8; i++) begin : g_gpr
    if (i == 6) begin : g_hole
      assign gpr[i] = alf_pkg::RST_BYTE;
    end else begin : g_reg
      always_ff @(posedge clk) begin
        if (srst) begin
          gpr[i] <= alf_pkg::RST_BYTE;
        end else if (ce && wr_ok && reg_addr == 8'(i)) begin
          gpr[i] <= reg_wdata;
        end else if (ce && wb_en && wb_idx == 3'(i)) begin
          gpr[i] <= new_res;
        end
      end
    end
  end

  // Flags take the datapath result on every commit.
  always_ff @(posedge clk) begin
    if (srst) begin
      flags <= alf_pkg::RST_BYTE;
    end else if (ce && wr_ok && reg_addr == alf_pkg::RA_FLAGS) begin
      flags <= reg_wdata;
    end else if (ce && commit) begin
      flags <= new_flags;
    end
  end

  // Index registers, prefix and operand byte.
  always_ff @(posedge clk) begin
    if (srst) begin
      ix <= 16'h0000;
      iy <= 16'h0000;
      prefix <= alf_pkg::RST_PREFIX;
      operand <= alf_pkg::RST_BYTE;
    end else if (ce && wr_ok) begin
      case (reg_addr)
        alf_pkg::RA_IXL: ix[7:0] <= reg_wdata;
        alf_pkg::RA_IXH: ix[15:8] <= reg_wdata;
        alf_pkg::RA_IYL: iy[7:0] <= reg_wdata;
        alf_pkg::RA_IYH: iy[15:8] <= reg_wdata;
        alf_pkg::RA_PREFIX: prefix <= reg_wdata[2:0];
        alf_pkg::RA_OPERAND: operand <= reg_wdata;
        default: prefix <= prefix;
      endcase
    end
  end

  // ----------------------------------------
  // Register read path.
  // ----------------------------------------
  // Unmapped offsets read as zero.
  always_comb begin
    rd_mux = 8'h00;
    if (reg_addr == alf_pkg::RA_FLAGS) begin
      rd_mux = flags;
    end else if (reg_addr < alf_pkg::RA_IXL) begin
      rd_mux = gpr[reg_addr[2:0]];
    end else begin
      case (reg_addr)
        alf_pkg::RA_IXL: rd_mux = ix[7:0];
        alf_pkg::RA_IXH: rd_mux = ix[15:8];
        alf_pkg::RA_IYL: rd_mux = iy[7:0];
        alf_pkg::RA_IYH: rd_mux = iy[15:8];
        alf_pkg::RA_PREFIX: rd_mux = {5'h00, prefix};
        alf_pkg::RA_OPERAND: rd_mux = operand;
        alf_pkg::RA_OPCODE: rd_mux = opcode;
        alf_pkg::RA_STATUS: rd_mux = {run, illegal, m_idx, t_idx};
        alf_pkg::RA_MEMBYTE: rd_mux = mem_byte;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end
endmodule
`default_nettype wire

// ===== core/alf_daa.sv
`default_nettype none
module alf_daa (
  // Accumulator and flags before the adjust.
  input wire logic [7:0] a,
  input wire logic [7:0] flags_in,
  // Adjusted accumulator and flags.
  output logic [7:0] result,
  output logic [7:0] flags_out
);
  // ----------------------------------------
  // Correction choice.
  // ----------------------------------------
  // The subtract flag picks the add or subtract column of corrections.
  wire n = flags_in[alf_pkg::FB_N];
  wire c = flags_in[alf_pkg::FB_C];
  wire h = flags_in[alf_pkg::FB_H];
  wire lo_fix = n ? h : (h || (a[3:0] > alf_pkg::DAA_LO_LIM));
  wire hi_fix = n ? c : (c || (a > alf_pkg::DAA_HI_LIM));
  wire [7:0] corr_add = (hi_fix ? alf_pkg::DAA_HI_ADD : 8'h00) |
      (lo_fix ? alf_pkg::DAA_LO_ADD : 8'h00);
  // Subtract corrections wrap modulo 256 on purpose.
  wire [7:0] corr_sub = (hi_fix ? alf_pkg::DAA_HI_SUB : 8'h00) +
      (lo_fix ? alf_pkg::DAA_LO_SUB : 8'h00);
  wire [7:0] corr = n ? corr_sub : corr_add;
  wire h_out = n ? (h && (a[3:0] < alf_pkg::DAA_LO_SUBLIM)) :
      (a[3:0] > alf_pkg::DAA_LO_LIM);
  // ----------------------------------------
  // Result and flags.
  // ----------------------------------------
  assign result = a + corr;
  assign flags_out = alf_pkg::alf_flags(result[7], result == 8'h00, h_out,
      ~^result, n, hi_fix);
endmodule
`default_nettype wire

// ===== dv/alf_core_bench.sv
`default_nettype none
module alf_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, reg_wr, reg_rd, mem_rd, busy, op_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, mem_rdata, mb;
  logic [15:0] mem_addr, ea;
  int fail_count, checks;
  alf_core dut_u (.clk(clk), .srst(srst), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .busy(busy),
    .op_done(op_done));
  // Clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Memory answers a clock later; otherwise it shows the inverse, so a late sample fails.
  always @(posedge clk) begin
    mem_rdata <= mem_rd ? mb : ~mb;
    if (mem_rd)
      chk(mem_addr, ea);
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask
  // Fields: prefix, opcode, acc, operand, flags, expected acc, expected flags.
  task automatic alu(input logic [55:0] v);
    int n;
    mb = v[31:24];
    wr(8'h00, v[31:24]);
    wr(8'h0d, v[31:24]);
    wr(8'h07, v[39:32]);
    wr(8'h06, v[23:16]);
    wr(8'h0c, v[55:48]);
    wr(8'h0e, v[47:40]);
    n = 0;
    while (op_done !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 30) begin
        fail_count++;
        complete_run;
      end
    end
    chk({15'h0000, busy}, 16'h0000);
    rd(8'h07, v[15:8]);
    rd(8'h06, v[7:0]);
  endtask
  task automatic arith_ops;
    alu(56'h00887f00018094);
    alu(56'h00901001000f12);
    alu(56'h0098000001ff93);
    alu(56'h00b84041004093);
    alu(56'h003c7f00018095);
    alu(56'h003d8000007f16);
    alu(56'h04448000008087);
    // Second register code: the sum only matches if C, not B, is the operand.
    wr(8'h01, 8'h22);
    alu(56'h00811000003200);
  endtask
  task automatic logic_ops;
    alu(56'h00a0f03c033014);
    alu(56'h00b08001138184);
    alu(56'h00a85555130044);
    alu(56'h002f5a00c5a5d7);
    alu(56'h003f1100c511d4);
    alu(56'h00372200d622c5);
    alu(56'h00273c00004214);
    alu(56'h00276600130047);
  endtask
  // Immediate and memory forms: for the memory reads, address and byte both come back through the responder.
  task automatic mem_ops;
    alu(56'h00c601ff000051);
    wr(8'h04, 8'h12);
    wr(8'h05, 8'h34);
    ea = 16'h1234;
    alu(56'h008e0f01011110);
    wr(8'h09, 8'h20);
    ea = 16'h1ffe;
    alu(56'h01a6fffe00fe90);
    wr(8'h0b, 8'h01);
    ea = 16'h0110;
    alu(56'h03b60110001104);
  endtask
  // Only negate is legal after the extended prefix; a refusal raises the status flag.
  task automatic refuse_op;
    wr(8'h0c, 8'h04);
    wr(8'h0e, 8'h80);
    rd(8'h0f, 8'h40);
    wr(8'h0f, 8'h40);
    rd(8'h0f, 8'h00);
  endtask
  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    mb = 8'h00;
    ea = 16'h0000;
    fail_count = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    arith_ops;
    logic_ops;
    mem_ops;
    refuse_op;
    complete_run;
  end
endmodule
`default_nettype wire

// ===== dv/alf_core_props.sv
`default_nettype none
module alf_core_props (
  // Clock and control.
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Register writes.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // Memory port and status.
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  input wire logic busy,
  input wire logic op_done
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst || !ce);
  // Prefix copy, since the same opcode times differently under another prefix.
  logic [2:0] pfx;
  always_ff @(posedge clk)
    if (srst)
      pfx <= 3'h0;
    else if (ce && reg_wr && !busy && reg_addr == alf_pkg::RA_PREFIX)
      pfx <= reg_wdata[2:0];
  // Accepted opcode writes, sorted by timing class.
  wire start = ce && reg_wr && !busy && reg_addr == alf_pkg::RA_OPCODE;
  wire alu_g = start && !pfx[2] && reg_wdata[7:6] == 2'h2;
  wire reg_op = alu_g && reg_wdata[2:0] != 3'h6;
  wire mem_op = alu_g && reg_wdata[2:0] == 3'h6;
  wire imm_op = start && !pfx[2] && reg_wdata[7:6] == 2'h3 && reg_wdata[2:0] == 3'h6;
  wire neg_op = start && pfx[2] && reg_wdata == alf_pkg::OPC_NEG;
  a_reg_four: assert property (reg_op |=> busy [*4] ##1 (!busy && op_done))
    else $error("register operation not four clocks");
  a_imm_seven: assert property (imm_op |=> busy [*7] ##1 (!busy && op_done))
    else $error("immediate operation not seven clocks");
  a_ptr_read: assert property (
    mem_op && !pfx[0] |=> (busy && !mem_rd) [*4] ##1 mem_rd ##1 busy [*2] ##1 !busy
  ) else $error("pointer read misplaced");
  // The read sits at the first T state of the fifth machine cycle: clock 17 of 19.
  a_idx_read: assert property (
    mem_op && pfx[0] |=> (busy && !mem_rd) [*8] ##1 (busy && !mem_rd) [*8] ##1 mem_rd
    ##1 busy [*2] ##1 !busy) else $error("indexed read misplaced");
  a_neg_eight: assert property (neg_op |=> busy [*8] ##1 !busy)
    else $error("negate not eight clocks");
  a_one_read: assert property (mem_rd |=> !mem_rd [*4])
    else $error("second memory read");
  a_addr_hold: assert property (busy && $past(busy) |-> $stable(mem_addr))
    else $error("memory address moved");
  a_done_fall: assert property ($fell(busy) |-> op_done ##1 !op_done)
    else $error("done pulse wrong");
  cover property (mem_op && pfx[0]);
  cover property (neg_op);
  cover property ($fell(busy));
endmodule
bind alf_core alf_core_props chk_u (.clk(clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .mem_rd(mem_rd), .mem_addr(mem_addr),
  .busy(busy), .op_done(op_done));
`default_nettype wire

// ===== shared/alf_pkg.sv
`default_nettype none
package alf_pkg;
  // ----------------------------------------
  // Register map, one byte per offset.
  // ----------------------------------------
  localparam logic [7:0] RA_FLAGS = 8'h06;
  localparam logic [7:0] RA_IXL = 8'h08;
  localparam logic [7:0] RA_IXH = 8'h09;
  localparam logic [7:0] RA_IYL = 8'h0a;
  localparam logic [7:0] RA_IYH = 8'h0b;
  localparam logic [7:0] RA_PREFIX = 8'h0c;
  localparam logic [7:0] RA_OPERAND = 8'h0d;
  localparam logic [7:0] RA_OPCODE = 8'h0e;
  localparam logic [7:0] RA_STATUS = 8'h0f;
  localparam logic [7:0] RA_MEMBYTE = 8'h10;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_PREFIX = 3'h0;
  // ----------------------------------------
  // Field positions.
  // ----------------------------------------
  localparam int FB_S = 7;
  localparam int FB_Z = 6;
  localparam int FB_H = 4;
  localparam int FB_PV = 2;
  localparam int FB_N = 1;
  localparam int FB_C = 0;
  localparam int PB_INDEXED = 0;
  localparam int PB_INDEX_SEL = 1;
  localparam int PB_EXT = 2;
  localparam int SB_BUSY = 7;
  localparam int SB_ILLEGAL = 6;
  // ----------------------------------------
  // Opcode fields and fixed opcodes.
  // ----------------------------------------
  localparam logic [2:0] RC_ACC = 3'h7;
  localparam logic [2:0] RC_MEM = 3'h6;
  localparam logic [2:0] RC_H = 3'h4;
  localparam logic [2:0] RC_L = 3'h5;
  localparam logic [1:0] OG_ALU = 2'h2;
  localparam logic [1:0] OG_IMM = 2'h3;
  localparam logic [1:0] OG_MISC = 2'h0;
  localparam logic [2:0] LO_IMM = 3'h6;
  localparam logic [2:0] LO_INC = 3'h4;
  localparam logic [2:0] LO_DEC = 3'h5;
  localparam logic [7:0] OPC_DAA = 8'h27;
  localparam logic [7:0] OPC_CPL = 8'h2f;
  localparam logic [7:0] OPC_SCF = 8'h37;
  localparam logic [7:0] OPC_CCF = 8'h3f;
  localparam logic [7:0] OPC_NEG = 8'h44;
  // ----------------------------------------
  // Timing: one T state is one enabled clock.
  // ----------------------------------------
  localparam logic [2:0] TS_FETCH = 3'h4;
  localparam logic [2:0] TS_READ = 3'h3;
  localparam logic [2:0] TS_IDX_ADD = 3'h5;
  localparam logic [2:0] MC_ONE = 3'h1;
  localparam logic [2:0] MC_TWO = 3'h2;
  localparam logic [2:0] MC_IDX = 3'h5;
  // ----------------------------------------
  // Arithmetic constants.
  // ----------------------------------------
  localparam logic [7:0] INC_OV_VAL = 8'h7f;
  localparam logic [7:0] DEC_OV_VAL = 8'h80;
  localparam logic [7:0] NEG_OV_VAL = 8'h80;
  localparam logic [7:0] DAA_LO_ADD = 8'h06;
  localparam logic [7:0] DAA_HI_ADD = 8'h60;
  localparam logic [7:0] DAA_LO_SUB = 8'hfa;
  localparam logic [7:0] DAA_HI_SUB = 8'ha0;
  localparam logic [7:0] DAA_HI_LIM = 8'h99;
  localparam logic [3:0] DAA_LO_LIM = 4'h9;
  localparam logic [3:0] DAA_LO_SUBLIM = 4'h6;
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_ADC = 4'h1, OP_SUB = 4'h2, OP_SBC = 4'h3,
    OP_AND = 4'h4, OP_XOR = 4'h5, OP_OR = 4'h6, OP_CP = 4'h7,
    OP_INC = 4'h8, OP_DEC = 4'h9, OP_CPL = 4'ha, OP_NEG = 4'hb,
    OP_CCF = 4'hc, OP_SCF = 4'hd, OP_DAA = 4'he
  } alf_op_e;
  typedef enum logic [2:0] {
    MD_REG = 3'h0, MD_IMM = 3'h1, MD_HL = 3'h2,
    MD_IDX = 3'h3, MD_EXT = 3'h4, MD_BAD = 3'h5
  } alf_mode_e;
  // Builds a flag byte; the two unused bits read as zero.
  function automatic logic [7:0] alf_flags(input logic s, input logic z,
      input logic h, input logic pv, input logic n, input logic c);
    logic [7:0] f;
    f = 8'h00;
    f[FB_S] = s;
    f[FB_Z] = z;
    f[FB_H] = h;
    f[FB_PV] = pv;
    f[FB_N] = n;
    f[FB_C] = c;
    return f;
  endfunction
endpackage
`default_nettype wire
